// [design/spi_seq_params.svh]
`ifndef SPI_SEQ_PARAMS_SVH
`define SPI_SEQ_PARAMS_SVH

`define OP_RAM_WRITE 8'h00
`define OP_RAM_READ 8'h40
`define OP_POWER_RESET 8'hf0
`define OP_INIT_RESET 8'hc0
`define OP_START_CONT 8'hcc
`define OP_WDOG_OFF 8'h9e
`define OP_BGAP_ON 8'h87
`define OP_BGAP_OFF 8'h86
`define OP_EE_EN_ON 8'h91
`define OP_EE_EN_OFF 8'h90
`define OP_BLOCK_ERASE 8'ha4
`define CFG_FIRST 8'h30
`define CFG_LAST 8'h42
`define CFG_VERIFY_LAST 8'h40
`define CFG_EPR_ADDR 8'h31
`define EPR_BITS_MASK 24'h000007
`define RESULT_ADDR 8'h00
`define CLK_HZ 40000000
`define SCK_HALF_NS 500
`define CS_PULSE_NS 500
`define RESET_WAIT_US 200
`define RESET_WAIT_AUTO_US 1000
`define RAM_WRITE_WAIT_US 10
`define SCK_HALF_CYC ((`SCK_HALF_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define CS_PULSE_CYC ((`CS_PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RESET_WAIT_CYC (`RESET_WAIT_US * (`CLK_HZ / 1000000))
`define RESET_WAIT_AUTO_CYC (`RESET_WAIT_AUTO_US * (`CLK_HZ / 1000000))
`define RAM_WRITE_WAIT_CYC (`RAM_WRITE_WAIT_US * (`CLK_HZ / 1000000))

`endif

// [design/spi_seq_pkg.sv]
package spi_seq_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_ER_RESET = 5'h01,
        ST_ER_BGAP = 5'h02,
        ST_ER_EN = 5'h03,
        ST_ER_BLOCK = 5'h04,
        ST_ER_BGOFF = 5'h05,
        ST_ER_ENOFF = 5'h06,
        ST_RESET = 5'h07,
        ST_WDOG = 5'h08,
        ST_CFG_WR = 5'h09,
        ST_CFG_RD = 5'h0a,
        ST_INIT = 5'h0b,
        ST_START = 5'h0c,
        ST_WAIT_RES = 5'h0d,
        ST_READ_RES = 5'h0e,
        ST_XFER = 5'h0f,
        ST_WAIT = 5'h10
    } seq_state_e;

    typedef logic [7:0] byte_t;
    typedef logic [23:0] word_t;
endpackage : spi_seq_pkg

// [design/spi_byte_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spi_seq_params.svh"

// One byte each way, phase 1 polarity 0, msb first; caller owns chip select
// so bytes can share a frame.
module spi_byte_shifter #(
    parameter int HALF_CYC = `SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Byte request
    input wire logic start,
    input wire logic [7:0] tx_byte,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte,
    // Pins
    output logic sck,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        if (HALF_CYC < 1) $error("HALF_CYC must be at least 1");
    end

    logic [15:0] div_r;
    logic [3:0] edges_r;
    logic [7:0] sh_r;
    logic tick;

    assign tick = busy && (div_r == 16'(HALF_CYC - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= 16'h0000;
        end else if (!busy || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // Rise launches a bit, fall captures it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            edges_r <= 4'h0;
            sck <= 1'b0;
            sh_r <= 8'h00;
            rx_byte <= 8'h00;
            serial_data_in <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                edges_r <= 4'h0;
                sh_r <= tx_byte;
            end else if (tick) begin
                sck <= ~sck; // see RL14
                if (!sck) begin
                    serial_data_in <= sh_r[7]; // see RL18
                end else begin
                    sh_r <= {sh_r[6:0], serial_data_out};
                    if (edges_r == 4'h7) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        rx_byte <= {sh_r[6:0], serial_data_out};
                    end
                    edges_r <= edges_r + 4'h1;
                end
            end
        end
    end
endmodule : spi_byte_shifter
`default_nettype wire

// [design/spi_meas_host.sv]
// Function
// RL1 - Start with power reset 0xf0 then watchdog off 0x9e before configuring.
// RL2 - Write each config address 48..66: opcode 0x00, address, three data bytes.
// RL3 - Clear bits 0..2 of config word 49 when running without EEPROM.
// RL4 - Optionally read back config addresses 48..64 with opcode 0x40.
// RL5 - After configuring send init reset 0xc0 then continuous start 0xcc.
// RL6 - Device signals a new result by a high to low data output edge.
// RL7 - That indication follows the last discharge cycle of a measurement.
// RL8 - On the edge pulse chip select low, high, low to restore data mode.
// RL9 - Read result: opcode 0x40 and address 0, then three result bytes.
// RL10 - Read the result at address 0, never its duplicate at address 20.
// RL11 - Device copies each result to address 0 when EEPROM holds no program.
// RL12 - Hold the serial port enable high so the device pins act as SPI.
// RL13 - Erase EEPROM: reset, bandgap on, enable, erase blocks 0..3, off, off.
// RL14 - SPI mode phase 1 polarity 0: clock idles low, data change on rise.
// RL15 - Pulse active low chip select high before every opcode.
// RL16 - Wait 200 us after a reset opcode, or 1 ms with auto configuration.
// RL17 - Wait at least 10 us after each RAM write.
// RL18 - Multi-byte words go most significant byte first, msb first.
`timescale 1ns/1ps
`default_nettype none
`include "spi_seq_params.svh"

module spi_meas_host #(
    parameter int RESET_WAIT = `RESET_WAIT_CYC,
    parameter int RESET_WAIT_AUTO = `RESET_WAIT_AUTO_CYC,
    parameter int RAM_WAIT = `RAM_WRITE_WAIT_CYC,
    parameter int HALF_CYC = `SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // User control
    input wire logic go,
    input wire logic erase_first,
    input wire logic verify_cfg,
    input wire logic auto_cfg,
    // Configuration source, word for cfg_addr
    output logic [7:0] cfg_addr,
    input wire logic [23:0] cfg_data,
    // Results
    output logic [23:0] bridge_result,
    output logic result_valid,
    output logic [23:0] verify_data,
    output logic verify_valid,
    output logic verify_error,
    output logic running,
    // Device pins
    output logic serial_port_enable,
    output logic chip_select_n,
    output logic sck,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        if (RESET_WAIT < 1 || RESET_WAIT_AUTO < 1 || RAM_WAIT < 1 || HALF_CYC < 1)
            $error("Wait counts must be at least 1");
    end

    spi_seq_pkg::seq_state_e state_r, ret_r;
    logic [2:0] nbytes_r, idx_r;
    logic [7:0] b0_r, b1_r, b2_r, b3_r, b4_r;
    logic [23:0] rx_r;
    logic [31:0] wait_r, post_wait_r;
    logic [1:0] blk_r;
    logic [1:0] cs_ph_r;
    logic [15:0] cs_cnt_r;
    logic do_prev_r;
    logic sh_start, sh_busy, sh_done;
    logic [7:0] sh_tx, sh_rx;
    logic [23:0] cfg_wr_word;

    // Picks the byte of a queued frame
    function automatic logic [7:0] frame_byte(input logic [2:0] i, input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] c, input logic [7:0] d,
            input logic [7:0] e);
        if (i == 3'h0) frame_byte = a;
        else if (i == 3'h1) frame_byte = b;
        else if (i == 3'h2) frame_byte = c;
        else if (i == 3'h3) frame_byte = d;
        else frame_byte = e;
    endfunction : frame_byte

    // No EEPROM boot or program in host mode
    function automatic logic [23:0] cfg_masked(input logic [7:0] a, input logic [23:0] d);
        cfg_masked = (a == `CFG_EPR_ADDR) ? (d & ~`EPR_BITS_MASK) : d; // see RL3
    endfunction : cfg_masked

    assign serial_port_enable = 1'b1; // see RL12
    assign sh_tx = frame_byte(idx_r, b0_r, b1_r, b2_r, b3_r, b4_r);
    assign cfg_wr_word = cfg_masked(cfg_addr, cfg_data);
    assign sh_start = (state_r == spi_seq_pkg::ST_XFER) && (cs_ph_r == 2'h3) && !sh_busy
        && !sh_done && (idx_r < nbytes_r);

    spi_byte_shifter #(.HALF_CYC(HALF_CYC)) u_shifter (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(sh_start),
        .tx_byte(sh_tx),
        .busy(sh_busy),
        .done(sh_done),
        .rx_byte(sh_rx),
        .sck(sck),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            do_prev_r <= 1'b1;
        end else begin
            do_prev_r <= serial_data_out;
        end
    end

    // Frame: select high pulse, low setup, then bytes.
    // cs_ph_r: 0 none, 1 high pulse, 2 low setup, 3 shifting.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= spi_seq_pkg::ST_IDLE;
            ret_r <= spi_seq_pkg::ST_IDLE;
            nbytes_r <= 3'h0;
            idx_r <= 3'h0;
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            b3_r <= 8'h00;
            b4_r <= 8'h00;
            rx_r <= 24'h000000;
            wait_r <= 32'h0;
            post_wait_r <= 32'h0;
            blk_r <= 2'h0;
            cs_ph_r <= 2'h0;
            cs_cnt_r <= 16'h0000;
            chip_select_n <= 1'b1;
            cfg_addr <= `CFG_FIRST;
            bridge_result <= 24'h000000;
            result_valid <= 1'b0;
            verify_data <= 24'h000000;
            verify_valid <= 1'b0;
            verify_error <= 1'b0;
            running <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            verify_valid <= 1'b0;
            case (state_r)
                spi_seq_pkg::ST_IDLE: begin
                    if (go) begin
                        verify_error <= 1'b0;
                        running <= 1'b0;
                        blk_r <= 2'h0;
                        state_r <= erase_first ? spi_seq_pkg::ST_ER_RESET
                                               : spi_seq_pkg::ST_RESET;
                    end
                end
                spi_seq_pkg::ST_ER_RESET: begin
                    b0_r <= `OP_POWER_RESET; // see RL13
                    nbytes_r <= 3'h1;
                    post_wait_r <= auto_cfg ? 32'(RESET_WAIT_AUTO) : 32'(RESET_WAIT); // see RL16
                    ret_r <= spi_seq_pkg::ST_ER_BGAP;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_ER_BGAP: begin
                    b0_r <= `OP_BGAP_ON;
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_ER_EN;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_ER_EN: begin
                    b0_r <= `OP_EE_EN_ON;
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_ER_BLOCK;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_ER_BLOCK: begin
                    // Opcode, block_select_byte, then ignored low address and data word
                    b0_r <= `OP_BLOCK_ERASE; // see RL13
                    b1_r <= {6'h00, blk_r};
                    b2_r <= 8'h00;
                    b3_r <= 8'h00;
                    b4_r <= 8'h00;
                    nbytes_r <= 3'h5;
                    post_wait_r <= 32'(RAM_WAIT);
                    blk_r <= blk_r + 2'h1;
                    ret_r <= (blk_r == 2'h3) ? spi_seq_pkg::ST_ER_BGOFF
                                             : spi_seq_pkg::ST_ER_BLOCK;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_ER_BGOFF: begin
                    b0_r <= `OP_BGAP_OFF;
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_ER_ENOFF;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_ER_ENOFF: begin
                    b0_r <= `OP_EE_EN_OFF;
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_RESET;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_RESET: begin
                    b0_r <= `OP_POWER_RESET; // see RL1
                    nbytes_r <= 3'h1;
                    post_wait_r <= auto_cfg ? 32'(RESET_WAIT_AUTO) : 32'(RESET_WAIT); // see RL16
                    ret_r <= spi_seq_pkg::ST_WDOG;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_WDOG: begin
                    b0_r <= `OP_WDOG_OFF; // see RL1
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    cfg_addr <= `CFG_FIRST;
                    ret_r <= spi_seq_pkg::ST_CFG_WR;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_CFG_WR: begin
                    if (nbytes_r == 3'h5 && cfg_addr == `CFG_LAST) begin
                        cfg_addr <= `CFG_FIRST;
                        state_r <= verify_cfg ? spi_seq_pkg::ST_CFG_RD
                                              : spi_seq_pkg::ST_INIT;
                        ret_r <= spi_seq_pkg::ST_IDLE;
                    end else begin
                        if (nbytes_r == 3'h5) cfg_addr <= cfg_addr + 8'h01;
                        // Frame built next cycle once cfg_data follows cfg_addr
                        state_r <= spi_seq_pkg::ST_WAIT;
                        wait_r <= 32'h1;
                        ret_r <= spi_seq_pkg::ST_CFG_WR;
                        nbytes_r <= 3'h0;
                    end
                end
                spi_seq_pkg::ST_CFG_RD: begin
                    b0_r <= `OP_RAM_READ; // see RL4
                    b1_r <= cfg_addr;
                    b2_r <= 8'h00;
                    b3_r <= 8'h00;
                    b4_r <= 8'h00;
                    nbytes_r <= 3'h5;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_CFG_RD;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_INIT: begin
                    b0_r <= `OP_INIT_RESET; // see RL5
                    nbytes_r <= 3'h1;
                    post_wait_r <= auto_cfg ? 32'(RESET_WAIT_AUTO) : 32'(RESET_WAIT); // see RL16
                    ret_r <= spi_seq_pkg::ST_START;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_START: begin
                    b0_r <= `OP_START_CONT; // see RL5
                    nbytes_r <= 3'h1;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_WAIT_RES;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_WAIT_RES: begin
                    running <= 1'b1;
                    // Falling edge: new result; see RL6 see RL7
                    if (do_prev_r && !serial_data_out) begin
                        state_r <= spi_seq_pkg::ST_READ_RES;
                    end
                end
                spi_seq_pkg::ST_READ_RES: begin
                    // Select pulse before frame restores data mode; see RL8
                    b0_r <= `OP_RAM_READ; // see RL9
                    b1_r <= `RESULT_ADDR; // see RL10 see RL11
                    b2_r <= 8'h00;
                    b3_r <= 8'h00;
                    b4_r <= 8'h00;
                    nbytes_r <= 3'h5;
                    post_wait_r <= 32'h1;
                    ret_r <= spi_seq_pkg::ST_WAIT_RES;
                    state_r <= spi_seq_pkg::ST_XFER;
                end
                spi_seq_pkg::ST_XFER: begin
                    case (cs_ph_r)
                        2'h0: begin
                            chip_select_n <= 1'b1; // see RL15
                            cs_cnt_r <= 16'h0000;
                            idx_r <= 3'h0;
                            cs_ph_r <= 2'h1;
                        end
                        2'h1, 2'h2: begin
                            if (cs_cnt_r == 16'(`CS_PULSE_CYC - 1)) begin
                                chip_select_n <= 1'b0; // see RL8
                                cs_cnt_r <= 16'h0000;
                                cs_ph_r <= cs_ph_r + 2'h1;
                            end else begin
                                cs_cnt_r <= cs_cnt_r + 16'h0001;
                            end
                        end
                        default: begin
                            if (sh_done) begin
                                rx_r <= {rx_r[15:0], sh_rx}; // see RL18
                                idx_r <= idx_r + 3'h1;
                            end else if (!sh_busy && idx_r == nbytes_r) begin
                                cs_ph_r <= 2'h0;
                                wait_r <= post_wait_r;
                                state_r <= spi_seq_pkg::ST_WAIT;
                                if (ret_r == spi_seq_pkg::ST_WAIT_RES) begin
                                    bridge_result <= rx_r; // see RL9
                                    result_valid <= 1'b1;
                                end else if (ret_r == spi_seq_pkg::ST_CFG_RD) begin
                                    verify_data <= rx_r; // see RL4
                                    verify_valid <= 1'b1;
                                    if (rx_r != cfg_wr_word) verify_error <= 1'b1;
                                    if (cfg_addr == `CFG_VERIFY_LAST) begin
                                        ret_r <= spi_seq_pkg::ST_INIT;
                                    end else begin
                                        cfg_addr <= cfg_addr + 8'h01;
                                    end
                                end
                            end
                        end
                    endcase
                end
                spi_seq_pkg::ST_WAIT: begin
                    if (wait_r > 32'h1) begin
                        wait_r <= wait_r - 32'h1;
                    end else if (ret_r == spi_seq_pkg::ST_CFG_WR && nbytes_r == 3'h0) begin
                        b0_r <= `OP_RAM_WRITE; // see RL2
                        b1_r <= cfg_addr;
                        b2_r <= cfg_wr_word[23:16];
                        b3_r <= cfg_wr_word[15:8];
                        b4_r <= cfg_wr_word[7:0];
                        nbytes_r <= 3'h5;
                        post_wait_r <= 32'(RAM_WAIT); // see RL17
                        state_r <= spi_seq_pkg::ST_XFER;
                    end else begin
                        state_r <= ret_r;
                    end
                end
                default: state_r <= spi_seq_pkg::ST_IDLE;
            endcase
        end
    end
endmodule : spi_meas_host
`default_nettype wire

// [bench/spi_meas_host_props.sv]
`timescale 1ns/1ps
`default_nettype none

module spi_meas_host_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control and results
    input wire logic go,
    input wire logic [7:0] cfg_addr,
    input wire logic result_valid,
    input wire logic verify_valid,
    input wire logic verify_error,
    input wire logic running,
    // Device pins
    input wire logic serial_port_enable,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic serial_data_in,
    input wire logic serial_data_out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_port_enable_high: assert property (serial_port_enable)
        else $error("port enable low");
    a_sck_idle_low: assert property (chip_select_n |-> !sck)
        else $error("sck high deselected");
    a_cs_pulse_width: assert property ($rose(chip_select_n) |-> chip_select_n[*8])
        else $error("select pulse short");
    a_cs_setup_time: assert property ($fell(chip_select_n) |-> !sck[*8])
        else $error("sck too soon after select");
    a_data_hold_high: assert property (sck && !$rose(sck) |-> $stable(serial_data_in))
        else $error("data moved while sck high");
    a_data_at_fall: assert property ($fell(sck) |-> $stable(serial_data_in))
        else $error("data moved at fall");
    a_irq_cs_response: assert property (running && !chip_select_n && !$changed(sck)
        && $fell(serial_data_out) |-> ##[1:200] chip_select_n)
        else $error("no select pulse after result");
    a_result_one_cycle: assert property (result_valid |=> !result_valid)
        else $error("result valid too long");
    a_verify_one_cycle: assert property (verify_valid |=> !verify_valid)
        else $error("verify valid too long");
    a_cfg_addr_range: assert property (cfg_addr >= 8'h30 && cfg_addr <= 8'h42)
        else $error("config address out of range");
    a_verify_err_sticky: assert property (verify_error && !go |=> verify_error)
        else $error("verify error cleared");
endmodule : spi_meas_host_props

bind spi_meas_host spi_meas_host_props u_props (
    .ref_clk(ref_clk),
    .rst(rst),
    .go(go),
    .cfg_addr(cfg_addr),
    .result_valid(result_valid),
    .verify_valid(verify_valid),
    .verify_error(verify_error),
    .running(running),
    .serial_port_enable(serial_port_enable),
    .chip_select_n(chip_select_n),
    .sck(sck),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out)
);

`default_nettype wire

// [bench/spi_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

module spi_dev_model #(
    parameter int RAM_GAP = 5
) (
    // Bench control
    input wire logic [31:0] reset_gap,
    input wire logic corrupt_rd,
    // Device pins
    input wire logic serial_port_enable,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic serial_data_in,
    output logic serial_data_out = 1'b1
);
    logic [23:0] ram [0:255];
    logic [7:0] rx_log [$];
    logic [7:0] sh, op, addr;
    logic [23:0] wd, rd_word;
    int nb = 0;
    int need = 0;
    int errs = 0;
    realtime last_end = 0.0;

    // Gap checked at next opcode; 25 ns per host cycle
    always @(negedge chip_select_n) begin
        nb = 0;
        if ($realtime - last_end < need * 25.0)
            errs++;
        if (!serial_port_enable || sck)
            errs++;
    end

    always @(posedge chip_select_n)
        serial_data_out = 1'b1; // Select pulse returns the line to data mode

    always @(negedge sck) begin
        if (!chip_select_n) begin
            sh = {sh[6:0], serial_data_in};
            wd = {wd[22:0], serial_data_in};
            nb++;
            if (nb == 8)
                op = sh;
            if (nb == 16) begin
                addr = sh;
                rd_word = ram[addr];
                if (op == 8'h40 && addr == 8'h14)
                    errs++;
            end
            if (nb == 40 && op == 8'h00)
                ram[addr] = wd;
            // Line idles high again after the last bit
            if (nb == 40 && op == 8'h40)
                serial_data_out <= #50 1'b1;
            if (nb % 8 == 0) begin
                rx_log.push_back(sh);
                last_end = $realtime;
                need = (op == 8'hf0 || op == 8'hc0) ? int'(reset_gap) : 0;
                if (nb == 40 && op == 8'h00)
                    need = RAM_GAP;
            end
        end
    end

    // Launch on rise, host samples on fall
    always @(posedge sck) begin
        if (!chip_select_n && op == 8'h40 && nb >= 16 && nb < 40)
            serial_data_out = rd_word[39 - nb] ^ (corrupt_rd && addr != 8'h00);
    end

    task automatic post_result(input logic [23:0] w);
        ram[8'h00] = w;
        serial_data_out = 1'b0; // After last discharge
    endtask : post_result
endmodule : spi_dev_model

`default_nettype wire

// [bench/spi_meas_host_test.sv]
`timescale 1ns/1ps
`default_nettype none

module spi_meas_host_test;
    localparam int RW = 20;
    localparam int RWA = 40;
    localparam int RAMW = 5;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0, erase_first = 1'b0, verify_cfg = 1'b0, auto_cfg = 1'b0;
    logic corrupt_rd = 1'b0;
    logic [31:0] reset_gap = RW;
    logic [7:0] cfg_addr;
    logic [23:0] cfg_data, bridge_result, verify_data;
    logic result_valid, verify_valid, verify_error, running;
    logic serial_port_enable, chip_select_n, sck, serial_data_in, serial_data_out;
    logic [7:0] exp_q [$];
    int n_fail = 0;
    int check_count = 0;
    int n_verify = 0;

    // Low bits of 49 set so clearing shows
    assign cfg_data = {cfg_addr, ~cfg_addr, cfg_addr | 8'h07};

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    spi_meas_host #(.RESET_WAIT(RW), .RESET_WAIT_AUTO(RWA), .RAM_WAIT(RAMW), .HALF_CYC(2)) DUT (
        .ref_clk(ref_clk), .rst(rst), .go(go), .erase_first(erase_first),
        .verify_cfg(verify_cfg), .auto_cfg(auto_cfg), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
        .bridge_result(bridge_result), .result_valid(result_valid), .verify_data(verify_data),
        .verify_valid(verify_valid), .verify_error(verify_error), .running(running),
        .serial_port_enable(serial_port_enable), .chip_select_n(chip_select_n), .sck(sck),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out)
    );

    spi_dev_model #(.RAM_GAP(RAMW)) dev (
        .reset_gap(reset_gap), .corrupt_rd(corrupt_rd), .serial_port_enable(serial_port_enable),
        .chip_select_n(chip_select_n), .sck(sck), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out)
    );

    always @(posedge ref_clk) begin
        if (verify_valid === 1'b1)
            n_verify++;
    end

    function automatic logic [23:0] cfg_word(input logic [7:0] a);
        cfg_word = {a, ~a, a | 8'h07};
        if (a == 8'h31)
            cfg_word[2:0] = 3'h0;
    endfunction : cfg_word

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Full sequence from reset, two results
    task automatic run_seq(input logic er, input logic vf, input logic au, input logic bad);
        int i, k;
        logic [23:0] w;
        logic [23:0] res [2] = '{24'hffffff, 24'h800001};
        rst = 1'b1;
        erase_first = er;
        verify_cfg = vf;
        auto_cfg = au;
        corrupt_rd = bad;
        reset_gap = au ? RWA : RW;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        dev.rx_log.delete();
        n_verify = 0;
        check_val({chip_select_n, sck, serial_data_in, running, result_valid}, 5'b10000);
        check_val(cfg_addr, 8'h30);
        exp_q.delete();
        for (i = 0; er && i < 4; i++)
            exp_q = {exp_q, 8'ha4, i[7:0], 8'h00, 8'h00, 8'h00};
        if (er)
            exp_q = {8'hf0, 8'h87, 8'h91, exp_q, 8'h86, 8'h90};
        exp_q = {exp_q, 8'hf0, 8'h9e};
        for (i = 48; i <= 66; i++) begin
            w = cfg_word(i[7:0]);
            exp_q = {exp_q, 8'h00, i[7:0], w[23:16], w[15:8], w[7:0]};
        end
        for (i = 48; vf && i <= 64; i++)
            exp_q = {exp_q, 8'h40, i[7:0], 8'h00, 8'h00, 8'h00};
        exp_q = {exp_q, 8'hc0, 8'hcc};
        go = 1'b1;
        @(negedge ref_clk);
        go = 1'b0;
        for (i = 0; i < 30000 && running !== 1'b1; i++)
            @(negedge ref_clk);
        for (k = 0; k < 2; k++) begin
            repeat (10) @(negedge ref_clk);
            dev.post_result(res[k]);
            exp_q = {exp_q, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
            for (i = 0; i < 3000 && result_valid !== 1'b1; i++)
                @(negedge ref_clk);
            check_val(bridge_result, res[k]);
        end
        check_val(dev.rx_log.size(), exp_q.size());
        foreach (exp_q[j])
            check_val(dev.rx_log[j], exp_q[j]);
        check_val(n_verify, vf ? 17 : 0);
        check_val(verify_error, vf && bad);
        check_val(dev.errs, 0);
    endtask : run_seq

    initial begin
        run_seq(1'b1, 1'b1, 1'b0, 1'b0);
        run_seq(1'b0, 1'b1, 1'b1, 1'b1);
        test_done();
    end

    // Runs take about 20000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
endmodule : spi_meas_host_test

`default_nettype wire
